// >>> core/mrie_exec.sv
// Execution unit for copy, store, load-literal, no-operation and return instructions
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Copy goes to accumulator or back to register
// - Copy sets zero flag from moved value
// - Store writes accumulator to register, flags kept
// - Load literal fills accumulator, flags kept
// - Return from interrupt pops stack into PC
// - Return from interrupt sets interrupt allow bit
// - Return from interrupt takes two cycles
// - Return with literal loads accumulator, flags kept
// - Return with literal pops stack into PC
// - Return with literal takes two cycles
module mrie_exec
    import mrie_pkg::*;
#(
    parameter int PC_W = MRIE_PC_W
)
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic clkEn,
    // Instruction fetch
    input wire logic instrValid,
    input wire logic [13:0] instrWord,
    output logic instrReady,
    // File register read port
    output logic [6:0] fileRdAddr,
    input wire logic [7:0] fileRdData,
    // File register write and control strobes
    output mrie_fwrite_s fileWr,
    output mrie_ctrl_s ctrl,
    // Stack top and program counter
    input wire logic [PC_W-1:0] stackTopEntry,
    output logic [PC_W-1:0] progCounter,
    // Accumulator, zero flag, interrupt allow
    output logic [7:0] accum,
    output logic zeroFlag,
    output logic globalInterruptAllow,
    // Set bit position in the interrupt control register
    output logic [2:0] allowBitPos,
    output logic busy
);
    // Refuse program counter widths the logic cannot carry
    if (PC_W < 1 || PC_W > 16)
    begin : g_pcw_check
        $error("PC_W out of range");
    end

    mrie_instr_e kind;
    logic destFile;
    logic [6:0] fAddr;
    logic [7:0] lit;

    // Zero test shared by the flag update and the zero pulse
    function automatic logic isZero(input logic [7:0] v);
        return (v == 8'h00);
    endfunction

    mrie_decode uDec (
        .instrWord(instrWord),
        .instrKind(kind),
        .destFile(destFile),
        .fileAddr(fAddr),
        .literal(lit)
    );

    logic [7:0] accum_r, accum_nxt;
    logic zero_r, zero_nxt;
    logic allow_r, allow_nxt;
    logic [PC_W-1:0] pc_r, pc_nxt;
    logic [1:0] cyc_r, cyc_nxt;
    mrie_fwrite_s fw_r, fw_nxt;
    mrie_ctrl_s ct_r, ct_nxt;

    // Second cycle of a return is a dead slot; fetch stalls meanwhile
    assign instrReady = (cyc_r == 2'h0);
    wire logic take = clkEn && instrValid && instrReady;

    always_comb
    begin
        accum_nxt = accum_r;
        zero_nxt = zero_r;
        allow_nxt = allow_r;
        pc_nxt = pc_r;
        cyc_nxt = cyc_r;
        fw_nxt = '0;
        ct_nxt = '0;
        if (cyc_r != 2'h0)
        begin
            cyc_nxt = cyc_r - 2'h1;
        end
        else if (take)
        begin
            pc_nxt = pc_r + PC_W'(1);
            case (kind)
                MRIE_I_COPY:
                begin
                    if (destFile)
                    begin
                        fw_nxt.fileWe = 1'b1;
                        fw_nxt.fileAddr = fAddr;
                        fw_nxt.fileData = fileRdData;
                    end
                    else
                        accum_nxt = fileRdData;
                    zero_nxt = isZero(fileRdData);
                    ct_nxt.zeroWe = 1'b1;
                    ct_nxt.zeroVal = isZero(fileRdData);
                end
                MRIE_I_STORE:
                begin
                    fw_nxt.fileWe = 1'b1;
                    fw_nxt.fileAddr = fAddr;
                    fw_nxt.fileData = accum_r;
                end
                MRIE_I_LOADLIT:
                    accum_nxt = lit;
                MRIE_I_RETINT:
                begin
                    pc_nxt = stackTopEntry;
                    ct_nxt.stackPop = 1'b1;
                    allow_nxt = 1'b1;
                    ct_nxt.allowSet = 1'b1;
                    cyc_nxt = MRIE_CYC_TWO - 2'h1;
                end
                MRIE_I_RETLIT:
                begin
                    accum_nxt = lit;
                    pc_nxt = stackTopEntry;
                    ct_nxt.stackPop = 1'b1;
                    cyc_nxt = MRIE_CYC_TWO - 2'h1;
                end
                MRIE_I_NOOP:
                    pc_nxt = pc_r + PC_W'(1);
                default:
                    pc_nxt = pc_r + PC_W'(1);
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            accum_r <= MRIE_ACC_RST;
            zero_r <= 1'b0;
            allow_r <= 1'b0;
            pc_r <= PC_W'(MRIE_PC_RST);
            cyc_r <= 2'h0;
            fw_r <= '0;
            ct_r <= '0;
        end
        else if (clkEn)
        begin
            accum_r <= accum_nxt;
            zero_r <= zero_nxt;
            allow_r <= allow_nxt;
            pc_r <= pc_nxt;
            cyc_r <= cyc_nxt;
            fw_r <= fw_nxt;
            ct_r <= ct_nxt;
        end
    end

    // Counts enabled cycles with fetch stalled; a return may stall only one
    logic [1:0] stallCnt_r, stallCnt_nxt;

    always_comb
    begin
        stallCnt_nxt = 2'h0;
        if (!instrReady)
            stallCnt_nxt = (stallCnt_r == 2'h3) ? stallCnt_r : stallCnt_r + 2'h1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            stallCnt_r <= 2'h0;
        else if (clkEn)
            stallCnt_r <= stallCnt_nxt;
    end

    assign fileRdAddr = fAddr;
    assign fileWr = fw_r;
    assign ctrl = ct_r;
    assign progCounter = pc_r;
    assign accum = accum_r;
    assign zeroFlag = zero_r;
    assign globalInterruptAllow = allow_r;
    assign allowBitPos = 3'(MRIE_ALLOW_BIT);
    assign busy = (cyc_r != 2'h0);

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // Core effect of each instruction
    a_copy_acc: assert property (take && kind == MRIE_I_COPY && !destFile
        |=> accum_r == $past(fileRdData))
        else $error("copy to accumulator wrong");
    a_copy_file: assert property (take && kind == MRIE_I_COPY && destFile
        |=> fw_r.fileWe && fw_r.fileData == $past(fileRdData))
        else $error("copy to file wrong");
    a_copy_zero: assert property (take && kind == MRIE_I_COPY
        |=> zero_r == ($past(fileRdData) == 8'h00))
        else $error("zero flag wrong");
    a_store_flags: assert property (take && kind == MRIE_I_STORE
        |=> fw_r.fileData == $past(accum_r) && $stable(zero_r))
        else $error("store wrong");
    a_lit_load: assert property (take && kind == MRIE_I_LOADLIT
        |=> accum_r == $past(lit) && $stable(zero_r))
        else $error("literal load wrong");
    a_retint_pc: assert property (take && kind == MRIE_I_RETINT
        |=> pc_r == $past(stackTopEntry) && allow_r && ct_r.stackPop)
        else $error("return from interrupt wrong");
    a_retint_two: assert property (take && kind == MRIE_I_RETINT
        |=> !instrReady ##1 (instrReady || !$past(clkEn)))
        else $error("return not two cycles");
    a_retlit_all: assert property (take && kind == MRIE_I_RETLIT
        |=> accum_r == $past(lit) && pc_r == $past(stackTopEntry)
            && $stable(zero_r) && !instrReady)
        else $error("return with literal wrong");
    a_noop_pc: assert property (take && kind == MRIE_I_NOOP
        |=> pc_r == $past(pc_r) + PC_W'(1) && $stable(accum_r) && !fw_r.fileWe)
        else $error("no-operation changed state");

    // Field and strobe details of the moves
    a_copy_addr: assert property (take && kind == MRIE_I_COPY && destFile
        |=> fw_r.fileAddr == $past(fAddr))
        else $error("copy address wrong");
    a_copy_strobe: assert property (take && kind == MRIE_I_COPY
        |=> ct_r.zeroWe && ct_r.zeroVal == ($past(fileRdData) == 8'h00) && !ct_r.stackPop)
        else $error("copy zero pulse wrong");
    a_zero_source: assert property ($changed(zero_r)
        |-> $past(take && kind == MRIE_I_COPY))
        else $error("zero flag changed without copy");
    a_store_addr: assert property (take && kind == MRIE_I_STORE
        |=> fw_r.fileWe && fw_r.fileAddr == $past(fAddr) && ct_r == '0)
        else $error("store address wrong");
    a_store_keep: assert property (take && kind == MRIE_I_STORE
        |=> $stable(accum_r) && $stable(allow_r))
        else $error("store disturbed state");
    a_lit_strobes: assert property (take && kind == MRIE_I_LOADLIT
        |=> ct_r == '0 && !fw_r.fileWe && $stable(allow_r))
        else $error("literal load raised a strobe");
    a_acc_source: assert property ($changed(accum_r)
        |-> $past(take && ((kind == MRIE_I_COPY && !destFile)
            || kind == MRIE_I_LOADLIT || kind == MRIE_I_RETLIT)))
        else $error("accumulator changed without cause");

    // Returns and the dead slot
    a_retint_flags: assert property (take && kind == MRIE_I_RETINT
        |=> ct_r.allowSet && !ct_r.zeroWe && $stable(zero_r) && $stable(accum_r))
        else $error("return from interrupt touched flags");
    a_allow_source: assert property (ct_r.allowSet && $past(clkEn)
        |-> $past(take && kind == MRIE_I_RETINT))
        else $error("allow pulse without return");
    a_allow_rise: assert property ($rose(allow_r)
        |-> $past(take && kind == MRIE_I_RETINT))
        else $error("allow bit set without return");
    a_pop_source: assert property (ct_r.stackPop && $past(clkEn)
        |-> $past(take && (kind == MRIE_I_RETINT || kind == MRIE_I_RETLIT)))
        else $error("stack popped without return");
    a_pop_once: assert property (ct_r.stackPop && clkEn
        |=> !ct_r.stackPop)
        else $error("stack popped twice");
    a_retlit_keep: assert property (take && kind == MRIE_I_RETLIT
        |=> !ct_r.allowSet && !ct_r.zeroWe && !fw_r.fileWe && $stable(allow_r))
        else $error("return with literal touched flags");
    a_retlit_two: assert property (take && kind == MRIE_I_RETLIT
        |=> !instrReady ##1 (instrReady || !$past(clkEn)))
        else $error("return with literal not two cycles");
    a_dead_slot: assert property (busy && clkEn
        |=> ct_r == '0 && !fw_r.fileWe && $stable(pc_r) && $stable(accum_r))
        else $error("dead slot did work");
    a_stall_bound: assert property (stallCnt_r <= 2'h1)
        else $error("fetch stalled too long");

    // Program flow and enable
    a_noop_flags: assert property (take && kind == MRIE_I_NOOP
        |=> ct_r == '0 && $stable(zero_r) && $stable(allow_r))
        else $error("no-operation raised a strobe");
    a_other_pc: assert property (take && kind == MRIE_I_OTHER
        |=> pc_r == $past(pc_r) + PC_W'(1) && ct_r == '0 && !fw_r.fileWe && $stable(accum_r))
        else $error("unknown word did more than advance");
    a_pc_source: assert property ($changed(pc_r)
        |-> $past(take))
        else $error("program counter moved without a word");
    a_freeze_hold: assert property (!clkEn
        |=> $stable(pc_r) && $stable(accum_r) && $stable(zero_r) && $stable(allow_r)
            && $stable(cyc_r) && $stable(fw_r) && $stable(ct_r))
        else $error("state moved while disabled");

    c_copy: cover property (take && kind == MRIE_I_COPY && destFile);
    c_retint: cover property (take && kind == MRIE_I_RETINT);
    c_retlit: cover property (take && kind == MRIE_I_RETLIT);
    c_store: cover property (take && kind == MRIE_I_STORE);
    c_freeze: cover property (!clkEn && instrValid);
endmodule
`default_nettype wire

// >>> core/mrie_pkg.sv
// Package: opcodes, field layout and constants for the move/return execution block
package mrie_pkg;
    localparam int MRIE_WORD_W = 14;
    localparam int MRIE_DATA_W = 8;
    localparam int MRIE_FADDR_W = 7;
    localparam int MRIE_PC_W = 13;
    localparam int MRIE_DEST_BIT = 7;
    localparam int MRIE_ALLOW_BIT = 7;
    localparam logic [13:0] MRIE_OP_NOOP = 14'h0000;
    localparam logic [13:0] MRIE_OP_RETINT = 14'h0009;
    localparam logic [5:0] MRIE_PFX_COPY = 6'h08;
    localparam logic [6:0] MRIE_PFX_STORE = 7'h01;
    localparam logic [3:0] MRIE_PFX_LOADLIT = 4'hc;
    localparam logic [3:0] MRIE_PFX_RETLIT = 4'hd;
    localparam logic [1:0] MRIE_CYC_ONE = 2'h1;
    localparam logic [1:0] MRIE_CYC_TWO = 2'h2;
    localparam logic [7:0] MRIE_ACC_RST = 8'h00;
    localparam logic [12:0] MRIE_PC_RST = 13'h0000;

    typedef enum {
        MRIE_I_NOOP,
        MRIE_I_COPY,
        MRIE_I_STORE,
        MRIE_I_LOADLIT,
        MRIE_I_RETINT,
        MRIE_I_RETLIT,
        MRIE_I_OTHER
    } mrie_instr_e;

    typedef struct packed {
        logic [6:0] fileAddr;
        logic [7:0] fileData;
        logic fileWe;
    } mrie_fwrite_s;

    typedef struct packed {
        logic stackPop;
        logic allowSet;
        logic zeroWe;
        logic zeroVal;
    } mrie_ctrl_s;
endpackage

// >>> core/mrie_decode.sv
// Instruction word decoder for the move/return execution block
`timescale 1ns/10ps
`default_nettype none
module mrie_decode
    import mrie_pkg::*;
(
    // Instruction word
    input wire logic [13:0] instrWord,
    // Decoded class and fields
    output mrie_instr_e instrKind,
    output logic destFile,
    output logic [6:0] fileAddr,
    output logic [7:0] literal
);
    // Literal opcodes ignore their don't-care bits; a compliant source leaves them zero
    always_comb
    begin
        fileAddr = instrWord[6:0];
        literal = instrWord[7:0];
        destFile = instrWord[MRIE_DEST_BIT];
        if (instrWord == MRIE_OP_NOOP)
            instrKind = MRIE_I_NOOP;
        else if (instrWord == MRIE_OP_RETINT)
            instrKind = MRIE_I_RETINT;
        else if (instrWord[13:8] == MRIE_PFX_COPY)
            instrKind = MRIE_I_COPY;
        else if (instrWord[13:7] == MRIE_PFX_STORE)
            instrKind = MRIE_I_STORE;
        else if (instrWord[13:10] == MRIE_PFX_LOADLIT)
            instrKind = MRIE_I_LOADLIT;
        else if (instrWord[13:10] == MRIE_PFX_RETLIT)
            instrKind = MRIE_I_RETLIT;
        else
            instrKind = MRIE_I_OTHER;
    end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking testbench for the move/return execution block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import mrie_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic clkEn = 1'b0;
    logic instrValid = 1'b0;
    logic [13:0] instrWord = 14'h0000;
    logic [7:0] fileRdData = 8'h00;
    logic [12:0] stackTopEntry = 13'h0000;
    logic instrReady, zeroFlag, allow, busy;
    logic [6:0] fileRdAddr;
    logic [12:0] progCounter;
    logic [7:0] accum;
    logic [2:0] allowBitPos;
    mrie_fwrite_s fileWr;
    mrie_ctrl_s ctrl;
    int fail_count = 0;
    int n_compared = 0;
    logic [12:0] pcExp = 13'h0000;

    always #2 clk = ~clk;

    mrie_exec dut (.clk(clk), .nrst(nrst), .clkEn(clkEn), .instrValid(instrValid),
        .instrWord(instrWord), .instrReady(instrReady), .fileRdAddr(fileRdAddr),
        .fileRdData(fileRdData), .fileWr(fileWr), .ctrl(ctrl),
        .stackTopEntry(stackTopEntry), .progCounter(progCounter), .accum(accum),
        .zeroFlag(zeroFlag), .globalInterruptAllow(allow), .allowBitPos(allowBitPos),
        .busy(busy));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // One word taken; read data and stack top are scrambled once consumed
    task automatic issue(input logic [13:0] w, input logic [7:0] d, input logic [12:0] s);
        @(posedge clk);
        instrValid <= 1'b1;
        instrWord <= w;
        fileRdData <= d;
        stackTopEntry <= s;
        @(posedge clk);
        instrValid <= 1'b0;
        fileRdData <= ~d;
        stackTopEntry <= ~s;
        #1;
    endtask

    // Strobes packed as stackPop, allowSet, zeroWe, zeroVal, fileWe
    function automatic logic [15:0] strb();
        return 16'({ctrl, fileWr.fileWe});
    endfunction

    task automatic test_copy();
        issue({MRIE_PFX_COPY, 1'b1, 7'h55}, 8'ha5, 13'h0000);
        pcExp = pcExp + 13'h0001;
        chk(16'({fileWr.fileAddr, fileWr.fileData}), 16'h55a5);
        chk(16'(fileRdAddr), 16'h0055);
        chk(strb(), 16'h0005);
        chk(16'({zeroFlag, accum}), 16'h0000);
        issue({MRIE_PFX_COPY, 1'b0, 7'h12}, 8'h00, 13'h0000);
        pcExp = pcExp + 13'h0001;
        chk(16'({zeroFlag, accum}), 16'h0100);
        chk(strb(), 16'h0006);
        chk(16'(progCounter), 16'(pcExp));
        $display("done copy");
    endtask

    task automatic test_load_store();
        issue({MRIE_PFX_LOADLIT, 2'b00, 8'hff}, 8'h00, 13'h0000);
        pcExp = pcExp + 13'h0001;
        chk(16'({zeroFlag, accum}), 16'h01ff);
        chk(strb(), 16'h0000);
        issue({MRIE_PFX_STORE, 7'h7f}, 8'h3c, 13'h0000);
        pcExp = pcExp + 13'h0001;
        chk(16'({fileWr.fileAddr, fileWr.fileData}), 16'h7fff);
        chk(strb(), 16'h0001);
        chk(16'(zeroFlag), 16'h0001);
        issue(MRIE_OP_NOOP, 8'h00, 13'h0000);
        pcExp = pcExp + 13'h0001;
        chk(strb(), 16'h0000);
        chk(16'({zeroFlag, accum}), 16'h01ff);
        chk(16'(progCounter), 16'(pcExp));
        $display("done load store noop");
    endtask

    // Return walk: pop and jump, one dead cycle, then ready again
    task automatic test_ret(input logic lit, input logic [12:0] s);
        issue(lit ? {MRIE_PFX_RETLIT, 2'b00, 8'h3c} : MRIE_OP_RETINT, 8'h00, s);
        chk(16'(progCounter), 16'(s));
        chk(strb(), lit ? 16'h0010 : 16'h0018);
        chk(16'({allow, allowBitPos}), lit ? 16'h0007 : 16'h000f);
        chk(16'({zeroFlag, accum}), 16'h013c);
        chk(16'({instrReady, busy}), 16'h0001);
        @(posedge clk);
        #1;
        chk(16'({instrReady, busy}), 16'h0002);
        chk(strb(), 16'h0000);
        chk(16'(progCounter), 16'(s));
        pcExp = s;
        $display("done return %0d", lit);
    endtask

    // Enable low: a presented word waits, then is taken once enabled
    task automatic test_freeze();
        @(posedge clk);
        clkEn <= 1'b0;
        instrValid <= 1'b1;
        instrWord <= {MRIE_PFX_LOADLIT, 2'b00, 8'h77};
        repeat (2) @(posedge clk);
        #1;
        chk(16'({zeroFlag, accum}), 16'h013c);
        chk(16'(progCounter), 16'(pcExp));
        @(posedge clk);
        clkEn <= 1'b1;
        @(posedge clk);
        instrValid <= 1'b0;
        pcExp = pcExp + 13'h0001;
        #1;
        chk(16'({zeroFlag, accum}), 16'h0177);
        chk(16'(progCounter), 16'(pcExp));
        $display("done freeze");
    endtask

    // Unknown word: only the program counter moves
    task automatic test_other();
        issue(14'h3fff, 8'h00, 13'h0000);
        pcExp = pcExp + 13'h0001;
        chk(strb(), 16'h0000);
        chk(16'({zeroFlag, accum}), 16'h0177);
        chk(16'(progCounter), 16'(pcExp));
        $display("done other");
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        clkEn <= 1'b1;
        #1;
        chk(16'({zeroFlag, allow, accum}), 16'h0000);
        chk(16'(progCounter), 16'h0000);
        test_copy();
        test_load_store();
        test_ret(1'b1, 13'h1abc);
        test_ret(1'b0, 13'h0123);
        test_freeze();
        test_other();
        issue(MRIE_OP_NOOP, 8'h00, 13'h0000);
        chk(16'(progCounter), 16'(pcExp + 13'h0001));
        results();
    end

    initial
    begin
        repeat (2000) @(posedge clk);
        fail_count++;
        results();
    end
endmodule
`default_nettype wire
